//--- logic/pcs_pkg.sv
package pcs_pkg;

	// Reference clock and the lamp flash and touch-down timings.
	localparam int unsigned CLK_HZ        = 25_000_000;
	localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
	localparam int unsigned SLOW_HALF_MS  = 500;
	localparam int unsigned FAST_HALF_MS  = 125;
	localparam int unsigned TOUCH_MS      = 2000;
	localparam int unsigned SLOW_HALF_CYC = SLOW_HALF_MS * CYC_PER_MS;
	localparam int unsigned FAST_HALF_CYC = FAST_HALF_MS * CYC_PER_MS;
	localparam int unsigned TOUCH_CYC     = TOUCH_MS * CYC_PER_MS;
	localparam int unsigned CNT_W         = 26;
	// Last initialization count; the four cycles spent are long enough to fill the synchronisers.
	localparam logic [1:0]  INIT_CYC      = 2'h3;
	// Reset values of the outputs that are not zero.
	localparam logic        PURGE_RST     = 1'b1;

	typedef enum logic [2:0] {
		ST_INIT,
		ST_GUARD,
		ST_READY,
		ST_ACCEL,
		ST_NORMAL,
		ST_DECEL,
		ST_FAILED
	} pcs_state_e;

	// Inputs from the panel, the control plug and the pump side.
	typedef struct packed {
		logic start_key;
		logic stop_key;
		logic remote_select_input_n;
		logic remote_start_input_n;
		logic mains_ok;
		logic supplies_ok;
		logic comm_session;
		logic touchdown;
		logic fault;
		logic warn;
		logic at_setpoint;
		logic standstill;
		logic tms_fitted;
		logic backing_fitted;
	} pcs_pins_s;

	typedef struct packed {
		logic status_green;
		logic status_red;
		logic main_green;
		logic com_green;
	} pcs_lamp_s;

	typedef struct packed {
		logic heater;
		logic backing;
		logic purge_valve;
		logic motor_run;
		logic braking;
	} pcs_act_s;

	typedef struct packed {
		pcs_pins_s              s1;
		pcs_pins_s              s2;
		logic                   start_prev;
		logic                   stop_prev;
		pcs_state_e             st;
		logic                   second_ack;
		logic [1:0]             init_cnt;
		logic [CNT_W-1:0]       slow_cnt;
		logic [CNT_W-1:0]       fast_cnt;
		logic [CNT_W-1:0]       td_cnt;
		logic                   slow_ph;
		logic                   fast_ph;
		pcs_lamp_s              lamp;
		pcs_act_s               act;
	} pcs_core_s;

endpackage : pcs_pkg

//--- logic/pcs_status_ctrl.sv
`timescale 1ns/10ps
// Overview of operation
// - run-up shows slow green flash
// - normal operation shows steady green
// - deceleration or buffering shows fast green flash
// - standstill switches status lamp off
// - main lamp green with power and supplies
// - main lamp flashes during kinetic buffering
// - communication lamp lit during serial session
// - select open: panel keys command pump
// - select grounded: remote start level commands
// - select and start inputs active low
// - continuous touch-down running shuts pump down
// - heater switched on at power-on if fitted
// - backing pump switched on at power-on if fitted
// - purge gas valve held open by default
// - stop command begins deceleration
// - stop key acknowledges removed failure
// - acceleration until setpoint, then normal operation
// - power-on hold, ready when nothing pending
// - after acknowledge, second acknowledge reaches ready
module pcs_status_ctrl #(
	parameter int unsigned SLOW_HALF = pcs_pkg::SLOW_HALF_CYC, // Slow flash
	parameter int unsigned FAST_HALF = pcs_pkg::FAST_HALF_CYC, // Fast flash
	parameter int unsigned TOUCH_LIM = pcs_pkg::TOUCH_CYC      // Touch-down
) (
	input  wire logic               ref_clk_i, // 25 MHz clock
	input  wire logic               rst_n_i,   // Synchronous reset
	input  wire logic               ce_i,      // Clock enable
	input  wire pcs_pkg::pcs_pins_s pins_i,    // Asynchronous inputs
	output pcs_pkg::pcs_state_e     state_o,   // Operating state
	output pcs_pkg::pcs_lamp_s      lamps_o,   // Front lamps
	output pcs_pkg::pcs_act_s       act_o      // Pump side actuators
);
	import pcs_pkg::*;

	pcs_core_s q;
	pcs_core_s d;
	pcs_pins_s p;
	logic      remote;
	logic      start_ev;
	logic      stop_ev;
	logic      run_cmd;
	logic      stop_cmd;
	logic      td_trip;
	logic      fail_now;
	logic      rotating;

	function automatic logic is_running(input pcs_state_e s);
		is_running = (s == ST_ACCEL) || (s == ST_NORMAL);
	endfunction : is_running

	assign p        = q.s2;
	// Ground on the select input chooses the plug over the keys.
	assign remote   = ~p.remote_select_input_n;
	assign start_ev = p.start_key & ~q.start_prev;
	assign stop_ev  = p.stop_key & ~q.stop_prev;
	// Remote start is a level: closed runs, open stops.
	assign run_cmd  = remote ? ~p.remote_start_input_n : start_ev;
	assign stop_cmd = remote ? p.remote_start_input_n : stop_ev;
	assign td_trip  = (q.td_cnt == CNT_W'(TOUCH_LIM - 1));
	assign fail_now = p.fault | td_trip;
	assign rotating = is_running(q.st) | (q.st == ST_DECEL);

	always_comb begin
		d = q;
		d.s1 = pins_i;
		d.s2 = q.s1;
		d.start_prev = p.start_key;
		d.stop_prev = p.stop_key;

		if (q.slow_cnt == CNT_W'(SLOW_HALF - 1)) begin
			d.slow_cnt = '0;
			d.slow_ph = ~q.slow_ph;
		end else begin
			d.slow_cnt = q.slow_cnt + CNT_W'(1);
		end
		if (q.fast_cnt == CNT_W'(FAST_HALF - 1)) begin
			d.fast_cnt = '0;
			d.fast_ph = ~q.fast_ph;
		end else begin
			d.fast_cnt = q.fast_cnt + CNT_W'(1);
		end

		// Brief shock contacts are tolerated; only a sustained run trips.
		if (p.touchdown && is_running(q.st) && !td_trip) begin
			d.td_cnt = q.td_cnt + CNT_W'(1);
		end else if (!p.touchdown || !is_running(q.st)) begin
			d.td_cnt = '0;
		end

		case (q.st)
			ST_INIT: begin
				d.init_cnt = q.init_cnt + 2'h1;
				if (q.init_cnt == INIT_CYC) begin
					d.act.heater = p.tms_fitted;
					d.act.backing = p.backing_fitted;
					d.st = ST_GUARD;
				end
			end
			ST_GUARD: begin
				if (q.second_ack) begin
					if (stop_ev && !p.fault) begin
						d.second_ack = 1'b0;
					end
				end else if (!p.fault && !p.warn) begin
					d.st = ST_READY;
				end
			end
			ST_READY: begin
				if (p.fault) begin
					d.st = ST_FAILED;
				end else if (run_cmd) begin
					d.st = ST_ACCEL;
				end
			end
			ST_ACCEL, ST_NORMAL: begin
				if (fail_now) begin
					d.st = ST_FAILED;
				end else if (stop_cmd || !p.mains_ok) begin
					d.st = ST_DECEL;
				end else if (q.st == ST_ACCEL && p.at_setpoint) begin
					d.st = ST_NORMAL;
				end
			end
			ST_DECEL: begin
				if (p.fault) begin
					d.st = ST_FAILED;
				end else if (p.standstill) begin
					d.st = ST_READY;
				end
			end
			ST_FAILED: begin
				if (stop_ev && !p.fault) begin
					d.st = ST_GUARD;
					d.second_ack = 1'b1;
				end
			end
			default: begin
				d.st = ST_INIT;
			end
		endcase

		d.act.purge_valve = PURGE_RST;
		d.act.motor_run = is_running(d.st);
		d.act.braking = (d.st == ST_DECEL);

		// Lamps follow the next state so they change with state_o.
		d.lamp.status_red = 1'b0;
		d.lamp.status_green = 1'b0;
		if (d.st == ST_FAILED) begin
			d.lamp.status_red = 1'b1;
		end else if (p.warn && d.st != ST_INIT) begin
			d.lamp.status_red = d.slow_ph;
		end else begin
			case (d.st)
				ST_ACCEL:  d.lamp.status_green = d.slow_ph;
				ST_NORMAL: d.lamp.status_green = 1'b1;
				ST_DECEL:  d.lamp.status_green = d.fast_ph;
				default:   d.lamp.status_green = 1'b0;
			endcase
		end
		if (p.mains_ok && p.supplies_ok) begin
			d.lamp.main_green = 1'b1;
		end else if (p.supplies_ok && rotating) begin
			d.lamp.main_green = d.fast_ph;
		end else begin
			d.lamp.main_green = 1'b0;
		end
		d.lamp.com_green = p.comm_session;
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			q <= '0;
			q.st <= ST_INIT;
			q.act.purge_valve <= PURGE_RST;
		end else if (ce_i) begin
			q <= d;
		end
	end

	assign state_o = q.st;
	assign lamps_o = q.lamp;
	assign act_o   = q.act;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i || !ce_i);

	sequence s_running_stop;
		is_running(q.st) && stop_cmd && !fail_now;
	endsequence

	sequence s_ack_taken;
		q.st == ST_FAILED && stop_ev && !p.fault;
	endsequence

	sequence s_remote_run;
		q.st == ST_READY && remote && !p.remote_start_input_n && !p.fault;
	endsequence

	sequence s_setpoint_seen;
		q.st == ST_ACCEL && p.at_setpoint && p.mains_ok && !fail_now
			&& !stop_cmd;
	endsequence

	sequence s_guard_clear;
		q.st == ST_GUARD && !q.second_ack && !p.fault && !p.warn;
	endsequence

	a_fail_red_lamp: assert property (
		q.st == ST_FAILED |-> lamps_o.status_red && !lamps_o.status_green)
		else $error("Failure not shown as steady red.");

	a_normal_green: assert property (
		q.st == ST_NORMAL && $past(ce_i) && !$past(p.warn)
			|-> lamps_o.status_green)
		else $error("Normal operation lamp not steady green.");

	a_ready_lamp_off: assert property (
		q.st == ST_READY |-> !lamps_o.status_green)
		else $error("Status lamp green at standstill.");

	a_stop_to_decel: assert property (
		s_running_stop |=> q.st == ST_DECEL && act_o.braking
			&& !act_o.motor_run)
		else $error("Stop command did not start deceleration.");

	a_touchdown_trip: assert property (
		is_running(q.st) && td_trip |=> q.st == ST_FAILED
			&& !act_o.motor_run)
		else $error("Continuous touch-down did not shut down.");

	a_ack_to_guard: assert property (
		s_ack_taken |=> q.st == ST_GUARD && q.second_ack)
		else $error("Acknowledge did not return to power-on hold.");

	a_second_ack_hold: assert property (
		q.st == ST_GUARD && q.second_ack && !stop_ev
			|=> q.st == ST_GUARD && q.second_ack)
		else $error("Left power-on hold without second acknowledge.");

	a_local_no_start: assert property (
		q.st == ST_READY && !remote && !start_ev && !p.fault
			|=> q.st == ST_READY)
		else $error("Pump started without a panel key press.");

	a_remote_run_acc: assert property (
		s_remote_run |=> q.st == ST_ACCEL && act_o.motor_run)
		else $error("Remote start level did not start the pump.");

	a_init_to_guard: assert property (
		q.st == ST_INIT && q.init_cnt == INIT_CYC |=> q.st == ST_GUARD)
		else $error("Initialization did not enter power-on hold.");

	// Lamps are registered from the synced pins of the previous edge, so
	// their checks look one cycle back, and only after an enabled edge.
	a_accel_slow_flash: assert property (
		q.st == ST_ACCEL && $past(ce_i) && !$past(p.warn)
			|-> lamps_o.status_green == q.slow_ph)
		else $error("Run-up lamp not flashing slowly.");

	a_decel_fast_flash: assert property (
		q.st == ST_DECEL && $past(ce_i) && !$past(p.warn)
			|-> lamps_o.status_green == q.fast_ph)
		else $error("Deceleration lamp not flashing fast.");

	a_main_lamp_on: assert property (
		$past(ce_i) && $past(p.mains_ok && p.supplies_ok)
			|-> lamps_o.main_green)
		else $error("Supply lamp dark with power present.");

	a_main_lamp_dark: assert property (
		$past(ce_i) && !$past(p.supplies_ok) |-> !lamps_o.main_green)
		else $error("Supply lamp lit without internal supplies.");

	a_main_buffer_flash: assert property (
		$past(ce_i) && !$past(p.mains_ok) && $past(p.supplies_ok)
			&& $past(rotating) |-> lamps_o.main_green == q.fast_ph)
		else $error("Supply lamp not flashing while buffering.");

	a_com_lamp: assert property (
		$past(ce_i) |-> lamps_o.com_green == $past(p.comm_session))
		else $error("Communication lamp does not follow session.");

	a_heater_at_init: assert property (
		q.st == ST_INIT && q.init_cnt == INIT_CYC
			|=> act_o.heater == $past(p.tms_fitted))
		else $error("Heater not switched at power-on.");

	a_backing_at_init: assert property (
		q.st == ST_INIT && q.init_cnt == INIT_CYC
			|=> act_o.backing == $past(p.backing_fitted))
		else $error("Backing pump not switched at power-on.");

	a_purge_open: assert property (
		act_o.purge_valve)
		else $error("Purge gas valve closed.");

	a_setpoint_normal: assert property (
		s_setpoint_seen |=> q.st == ST_NORMAL && act_o.motor_run)
		else $error("Setpoint did not lead to normal operation.");

	a_guard_release: assert property (
		s_guard_clear |=> q.st == ST_READY)
		else $error("Power-on hold not left with nothing pending.");

	a_guard_pending: assert property (
		q.st == ST_GUARD && (p.fault || p.warn) |=> q.st == ST_GUARD)
		else $error("Power-on hold left with a pending message.");

	a_standstill_ready: assert property (
		q.st == ST_DECEL && p.standstill && !p.fault
			|=> q.st == ST_READY && !act_o.motor_run)
		else $error("Standstill did not return to ready.");

endmodule : pcs_status_ctrl

//--- test/pcs_pump_model.sv
`timescale 1ns/10ps
// Rotor speed model; the ramps outlast one flash measuring window.
module pcs_pump_model #(
	parameter int unsigned TOP = 60 // Speed at setpoint
) (
	input  wire logic ref_clk_i, // Clock
	input  wire logic run_i,     // Motor drive on
	output logic      setp_o,    // Setpoint reached
	output logic      still_o    // Rotor stopped
);
	int unsigned speed_q = 0;
	always @(posedge ref_clk_i) begin
		if (run_i && speed_q < TOP)
			speed_q <= speed_q + 1;
		else if (!run_i && speed_q > 0)
			speed_q <= speed_q - 1;
	end
	assign setp_o  = (speed_q == TOP);
	assign still_o = (speed_q == 0);
endmodule : pcs_pump_model

//--- test/pcs_status_ctrl_test.sv
`timescale 1ns/10ps
module pcs_status_ctrl_test;
	import pcs_pkg::*;
	localparam int GRN = 3;
	localparam int RED = 2;
	localparam int MAIN = 1;
	// Columns: mains, supplies, session, main lamp, com lamp.
	localparam logic [4:0] ROWS [4] = '{5'h1F, 5'h10, 5'h05, 5'h1A};
	logic       ref_clk_i = 1'b0;
	logic       rst_n_i = 1'b0;
	logic       ce = 1'b1;
	pcs_pins_s  pin;
	pcs_pins_s  pins_w;
	pcs_state_e state_o;
	pcs_lamp_s  lamps_o;
	pcs_act_s   act_o;
	logic       setp;
	logic       still;
	int         n_errors = 0;
	int         samples_checked = 0;
	always #20 ref_clk_i = ~ref_clk_i;
	always_comb begin
		pins_w = pin;
		pins_w.at_setpoint = setp;
		pins_w.standstill = still;
	end
	pcs_status_ctrl #(.SLOW_HALF(4), .FAST_HALF(2), .TOUCH_LIM(8))
	pcs_status_ctrl_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.ce_i(ce), .pins_i(pins_w), .state_o(state_o),
		.lamps_o(lamps_o), .act_o(act_o));
	pcs_pump_model pcs_pump_model_i (.ref_clk_i(ref_clk_i),
		.run_i(act_o.motor_run), .setp_o(setp), .still_o(still));
	task test_done;
		$display("Checks %0d, errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done
	task chk(input logic ok, input string msg);
		samples_checked++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("Error at %0t: %s", $time, msg);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask : cyc
	// Keys need a low phase after each press for the edge detector.
	task press(input bit stop);
		@(posedge ref_clk_i);
		if (stop)
			pin.stop_key <= 1'b1;
		else
			pin.start_key <= 1'b1;
		cyc(4);
		@(posedge ref_clk_i);
		pin.stop_key <= 1'b0;
		pin.start_key <= 1'b0;
		cyc(4);
	endtask : press
	task wait_st(input pcs_state_e e);
		int i;
		for (i = 0; i < 300 && state_o !== e; i++)
			cyc(1);
		chk(state_o === e, "state not reached");
		if (state_o !== e)
			test_done();
	endtask : wait_st
	task flash(input int b, input int lo, input int hi);
		int n;
		logic p;
		n = 0;
		p = lamps_o[b];
		repeat (32) begin
			cyc(1);
			if (lamps_o[b] !== p)
				n++;
			p = lamps_o[b];
		end
		chk(n >= lo && n <= hi, "lamp flash rate");
	endtask : flash
	task ack_fail;
		@(posedge ref_clk_i);
		pin.fault <= 1'b0;
		pin.touchdown <= 1'b0;
		press(1);
		wait_st(ST_GUARD);
		cyc(8);
		chk(state_o === ST_GUARD, "ready without second ack");
		press(1);
		wait_st(ST_READY);
	endtask : ack_fail
	initial begin
		pin = '0;
		pin.remote_select_input_n = 1'b1;
		pin.remote_start_input_n = 1'b1;
		pin.mains_ok = 1'b1;
		pin.supplies_ok = 1'b1;
		pin.tms_fitted = 1'b1;
		pin.backing_fitted = 1'b1;
		repeat (12) @(posedge ref_clk_i);
		chk(state_o === ST_INIT && lamps_o === '0, "reset outputs");
		chk(act_o === 5'h04, "reset actuators");
		rst_n_i <= 1'b1;
		wait_st(ST_READY);
		chk(act_o.heater === 1'b1, "heater off");
		chk(act_o.backing === 1'b1, "backing pump off");
		chk(act_o.purge_valve === 1'b1, "purge closed");
		$display("Test reset finished");
		for (int r = 0; r < 4; r++) begin
			@(posedge ref_clk_i);
			pin.mains_ok <= ROWS[r][4];
			pin.supplies_ok <= ROWS[r][3];
			pin.comm_session <= ROWS[r][2];
			cyc(5);
			chk(lamps_o.main_green === ROWS[r][1], "main lamp");
			chk(lamps_o.com_green === ROWS[r][0], "com lamp");
		end
		$display("Test lamp table finished");
		press(0);
		wait_st(ST_ACCEL);
		chk(act_o.motor_run === 1'b1, "motor not driven");
		flash(GRN, 5, 9);
		wait_st(ST_NORMAL);
		flash(GRN, 0, 0);
		chk(lamps_o.status_green === 1'b1, "normal lamp");
		press(1);
		wait_st(ST_DECEL);
		chk(act_o.braking === 1'b1, "no braking");
		flash(GRN, 10, 17);
		wait_st(ST_READY);
		chk(lamps_o[GRN:RED] === 2'h0, "lamp lit at rest");
		$display("Test local run finished");
		press(0);
		wait_st(ST_NORMAL);
		@(posedge ref_clk_i);
		pin.mains_ok <= 1'b0;
		wait_st(ST_DECEL);
		flash(MAIN, 10, 17);
		@(posedge ref_clk_i);
		pin.mains_ok <= 1'b1;
		wait_st(ST_READY);
		$display("Test buffering finished");
		@(posedge ref_clk_i);
		pin.remote_start_input_n <= 1'b0;
		cyc(8);
		chk(state_o === ST_READY, "remote used while local");
		@(posedge ref_clk_i);
		pin.remote_start_input_n <= 1'b1;
		pin.remote_select_input_n <= 1'b0;
		press(0);
		chk(state_o === ST_READY, "key used while remote");
		@(posedge ref_clk_i);
		pin.remote_start_input_n <= 1'b0;
		wait_st(ST_ACCEL);
		@(posedge ref_clk_i);
		pin.remote_start_input_n <= 1'b1;
		wait_st(ST_DECEL);
		wait_st(ST_READY);
		@(posedge ref_clk_i);
		pin.remote_select_input_n <= 1'b1;
		$display("Test remote finished");
		@(posedge ref_clk_i);
		pin.fault <= 1'b1;
		wait_st(ST_FAILED);
		flash(RED, 0, 0);
		chk(lamps_o[GRN:RED] === 2'h1, "failure lamp");
		press(1);
		chk(state_o === ST_FAILED, "ack taken with cause");
		ack_fail();
		@(posedge ref_clk_i);
		pin.warn <= 1'b1;
		cyc(5);
		flash(RED, 5, 9);
		// With the clock enable low every lamp and the state must freeze.
		@(posedge ref_clk_i);
		ce <= 1'b0;
		cyc(1);
		flash(RED, 0, 0);
		chk(state_o === ST_READY, "state moved while frozen");
		@(posedge ref_clk_i);
		ce <= 1'b1;
		pin.warn <= 1'b0;
		cyc(5);
		$display("Test failure finished");
		press(0);
		wait_st(ST_ACCEL);
		@(posedge ref_clk_i);
		pin.touchdown <= 1'b1;
		cyc(5);
		chk(state_o !== ST_FAILED, "touch-down trip early");
		wait_st(ST_FAILED);
		ack_fail();
		$display("Test touch-down finished");
		@(posedge ref_clk_i);
		rst_n_i <= 1'b0;
		cyc(2);
		chk(state_o === ST_INIT && lamps_o === '0, "mid-run reset");
		chk(act_o === 5'h04, "mid-run reset actuators");
		@(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		wait_st(ST_READY);
		chk(act_o.heater === 1'b1, "heater off after reset");
		$display("Test mid-run reset finished");
		test_done();
	end
endmodule : pcs_status_ctrl_test
